// ===== core/ieeesr_pkg.sv
package ieeesr_pkg;

  // ----------------------------------------------------------------
  // Status byte bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SB_OPR_BIT = 7;
  localparam int unsigned SB_MSS_BIT = 6;
  localparam int unsigned SB_ESB_BIT = 5;
  localparam int unsigned SB_MAV_BIT = 4;
  localparam int unsigned SB_QUE_BIT = 3;
  localparam int unsigned SB_DVG_BIT = 2;

  // ----------------------------------------------------------------
  // Standard event bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SE_PON_BIT = 7;
  localparam int unsigned SE_NUL_BIT = 6;
  localparam int unsigned SE_CME_BIT = 5;
  localparam int unsigned SE_EXE_BIT = 4;
  localparam int unsigned SE_DDE_BIT = 3;
  localparam int unsigned SE_QYE_BIT = 2;
  localparam int unsigned SE_RQC_BIT = 1;
  localparam int unsigned SE_OPC_BIT = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned REG_W      = 8;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [7:0]  SB_FIX_EN  = 8'h40;  // Bit 6 of the mask always on
  localparam logic [7:0]  SB_LIVE_M  = 8'hbc;  // Bits 0 and 1 read zero
  localparam logic [7:0]  SE_LIVE_M  = 8'hbf;  // Bit 6 reads zero
  localparam logic [7:0]  PWRUP_EVT  = 8'h80;  // Power-on event set at reset

  // Standard event sources, one strobe per cause
  typedef struct packed {
    logic power_on;
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic query_err;
    logic req_ctrl;
    logic op_done;
  } ieeesr_evt_type;

  // Group summaries from the lower groups
  typedef struct packed {
    logic operation_group_summary;
    logic questionable_summary;
    logic device_group_summary;
    logic out_data_avail;
  } ieeesr_sum_type;

  // Host-side access strobes
  typedef struct packed {
    logic       poll;       // Serial poll by controller
    logic       stb_query;  // Status byte query
    logic       esr_query;  // Standard event query (reads and clears)
    logic       clr_status; // Clear-status common command
    logic       sre_wr;     // Write status byte mask
    logic       ese_wr;     // Write standard event mask
    logic [7:0] wdata;
  } ieeesr_req_type;

  // Serial poll state, Gray coded
  typedef enum logic [1:0] {
    SRQ_IDLE = 2'b00,
    SRQ_PEND = 2'b01,
    SRQ_HOLD = 2'b11
  } ieeesr_srq_type;

  // Or-reduce of an event/mask pair
  function automatic logic grp_summary(input logic [7:0] evt, input logic [7:0] en);
    grp_summary = |(evt & en);
  endfunction

endpackage

// ===== core/ieeesr_evt_grp.sv
`timescale 1ns/1ps
// Sticky event register with enable mask and summary for one status group
module ieeesr_evt_grp (
  input  wire logic                      ref_clk_i,  // Clock
  input  wire logic                      sys_rst_i,  // Sync reset, high
  input  wire logic [ieeesr_pkg::REG_W-1:0] set_i,   // Event set strobes
  input  wire logic [ieeesr_pkg::REG_W-1:0] live_m_i, // Implemented bits
  input  wire logic [ieeesr_pkg::REG_W-1:0] rst_val_i, // Event pattern held through reset
  input  wire logic                      clr_i,      // Clear (query or clear-status)
  input  wire logic                      en_wr_i,    // Mask write strobe
  input  wire logic [ieeesr_pkg::REG_W-1:0] en_wdata_i, // Mask write data
  output logic      [ieeesr_pkg::REG_W-1:0] evt_o,   // Event register
  output logic      [ieeesr_pkg::REG_W-1:0] en_o,    // Enable mask
  output logic                           sum_o       // Group summary
);
  import ieeesr_pkg::*;

  // ----------------------------------------------------------------
  // Event latch: set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      // Loading the pattern in reset means a query can never race a late set
      evt_o <= rst_val_i & live_m_i;
    end else if (clr_i) begin
      evt_o <= set_i & live_m_i;
    end else begin
      evt_o <= (evt_o | set_i) & live_m_i;
    end
  end

  // Mask holds whatever software writes
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      en_o <= ZERO_BYTE;
    end else if (en_wr_i) begin
      en_o <= en_wdata_i;
    end
  end

  // Summary registered so it is a flop output; one-cycle latency
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sum_o <= 1'b0;
    end else begin
      sum_o <= grp_summary(evt_o, en_o);
    end
  end

endmodule

// ===== core/ieeesr_status.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// - Condition inputs are live; software cannot write them.
// - Event bits latch until their query or clear-status.
// - Group summary is OR of event AND enable.
// - Enable masks hold any host-written value, except status byte mask bit 6.
// - Status byte summary appears as MSS in bit 6.
// - Status byte mask bit 6 is always enabled.
// - Rising MSS sets RQS, raising the service request.
// - Serial poll returns bits 0-5,7 with RQS; then RQS clears.
// - Poll clears nothing else; bits follow their sources.
// - Clear-status clears status events, RQS and MSS.
// - Status byte query returns MSS in bit 6, clears nothing.
// - MSS stays set while any enabled source stays set, except for the two cycles after clear-status, which hold it low.
// - Bit 7 carries operation group summary.
// - Bit 5 carries standard event summary.
// - Bit 4 follows output buffer data availability.
// - Bit 3 questionable, bit 2 device group, bits 0-1 zero.
// - Standard event bit 7 set at power up; bit 6 zero.
// - Standard event bit 5 set on command syntax error.
// - Standard event bit 4 set on execution error.
// - Standard event bit 3 set on other device errors.
// - Standard event bit 2 set on query error.
// - Bit 1 request control; bit 0 operation complete.
// ----------------------------------------------------------------
module ieeesr_status (
  input  wire logic                       ref_clk_i,   // 50 MHz clock
  input  wire logic                       sys_rst_i,   // Sync reset, high
  input  wire ieeesr_pkg::ieeesr_evt_type evt_i,       // Event cause strobes
  input  wire ieeesr_pkg::ieeesr_sum_type sum_i,       // Live lower summaries
  input  wire ieeesr_pkg::ieeesr_req_type req_i,       // Host strobes
  output logic                            srq_o,       // Service request
  output logic [7:0]                      poll_byte_o, // Serial poll answer
  output logic [7:0]                      stb_byte_o,  // Status byte query answer
  output logic [7:0]                      esr_byte_o,  // Standard event query answer
  output logic [7:0]                      sre_o,       // Status byte mask readback
  output logic [7:0]                      ese_o,       // Standard event mask readback
  output logic                            rd_valid_o   // Answer valid pulse
);
  import ieeesr_pkg::*;

  // ----------------------------------------------------------------
  // Standard event group
  // ----------------------------------------------------------------
  logic [7:0] se_set;
  logic [7:0] se_evt;
  logic [7:0] se_en;
  logic       esb_sum;

  // Map the event causes onto their bit positions
  always_comb begin
    se_set             = ZERO_BYTE;
    se_set[SE_PON_BIT] = evt_i.power_on;
    se_set[SE_NUL_BIT] = 1'b0;
    se_set[SE_CME_BIT] = evt_i.cmd_err;
    se_set[SE_EXE_BIT] = evt_i.exec_err;
    se_set[SE_DDE_BIT] = evt_i.dev_err;
    se_set[SE_QYE_BIT] = evt_i.query_err;
    se_set[SE_RQC_BIT] = evt_i.req_ctrl;
    se_set[SE_OPC_BIT] = evt_i.op_done;
  end

  ieeesr_evt_grp u_std_evt (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .set_i      (se_set),
    .live_m_i   (SE_LIVE_M),
    .rst_val_i  (PWRUP_EVT),                            // Power-on event from reset
    .clr_i      (req_i.esr_query | req_i.clr_status),
    .en_wr_i    (req_i.ese_wr),
    .en_wdata_i (req_i.wdata),
    .evt_o      (se_evt),
    .en_o       (se_en),
    .sum_o      (esb_sum)
  );

  // ----------------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------------
  logic [7:0] sb_live;
  logic [7:0] sre_q;
  logic       mss_q;
  logic       mss_prev_q;
  logic       rqs_q;
  logic       cls_hold_q;

  // Status byte bits follow their sources; they are not latched, so a
  // poll never clears them and they drop when the source drops
  always_comb begin
    sb_live             = ZERO_BYTE;
    sb_live[SB_OPR_BIT] = sum_i.operation_group_summary;
    sb_live[SB_ESB_BIT] = esb_sum;
    sb_live[SB_MAV_BIT] = sum_i.out_data_avail;
    sb_live[SB_QUE_BIT] = sum_i.questionable_summary;
    sb_live[SB_DVG_BIT] = sum_i.device_group_summary;
    sb_live             = sb_live & SB_LIVE_M;
  end

  // Status byte mask; bit 6 forced on regardless of writes
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sre_q <= SB_FIX_EN;
    end else if (req_i.sre_wr) begin
      sre_q <= req_i.wdata | SB_FIX_EN;
    end
  end

  // Clear-status holds the byte off for one cycle while the lower
  // summaries settle; live sources reassert afterwards
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cls_hold_q <= 1'b0;
    end else begin
      cls_hold_q <= req_i.clr_status;
    end
  end

  // Master summary recomputed over enabled bits each cycle, except the two cycles after clear-status, which force it low
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mss_q <= 1'b0;
    end else if (req_i.clr_status | cls_hold_q) begin
      // One more cycle low: the group summary still shows the cleared events
      mss_q <= 1'b0;
    end else begin
      mss_q <= grp_summary(sb_live & ~SB_FIX_EN, sre_q);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss_q;
    end
  end

  // ----------------------------------------------------------------
  // Request for service: rising MSS sets, poll or clear-status clears
  // ----------------------------------------------------------------
  ieeesr_srq_type srq_st_q;

  // New rising edge wins over a poll in the same cycle so it is not lost
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rqs_q    <= 1'b0;
      srq_st_q <= SRQ_IDLE;
    end else if (req_i.clr_status) begin
      rqs_q    <= 1'b0;
      srq_st_q <= SRQ_IDLE;
    end else begin
      case (srq_st_q)
        SRQ_IDLE: begin
          if (mss_q & ~mss_prev_q) begin
            rqs_q    <= 1'b1;
            srq_st_q <= SRQ_PEND;
          end
        end
        SRQ_PEND: begin
          if (mss_q & ~mss_prev_q) begin
            rqs_q <= 1'b1;
          end else if (req_i.poll) begin
            rqs_q    <= 1'b0;
            srq_st_q <= SRQ_HOLD;
          end
        end
        SRQ_HOLD: begin
          // Wait here until MSS drops or rises afresh
          if (mss_q & ~mss_prev_q) begin
            rqs_q    <= 1'b1;
            srq_st_q <= SRQ_PEND;
          end else if (~mss_q) begin
            srq_st_q <= SRQ_IDLE;
          end
        end
        default: begin
          rqs_q    <= 1'b0;
          srq_st_q <= SRQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      srq_o <= 1'b0;
    end else begin
      srq_o <= rqs_q & ~req_i.poll & ~req_i.clr_status;
    end
  end

  // ----------------------------------------------------------------
  // Read answers, registered one cycle after the strobe
  // ----------------------------------------------------------------
  logic [7:0] byte_base;
  assign byte_base = cls_hold_q ? ZERO_BYTE : sb_live;

  // Poll answer: RQS in bit 6 as it stood before the poll
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      poll_byte_o <= ZERO_BYTE;
    end else if (req_i.poll) begin
      poll_byte_o             <= byte_base;
      poll_byte_o[SB_MSS_BIT] <= rqs_q;
    end
  end

  // Status byte query: MSS in bit 6, no side effects
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stb_byte_o <= ZERO_BYTE;
    end else if (req_i.stb_query) begin
      stb_byte_o             <= byte_base;
      stb_byte_o[SB_MSS_BIT] <= mss_q;
    end
  end

  // Standard event query answer; the group clears in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      esr_byte_o <= ZERO_BYTE;
    end else if (req_i.esr_query) begin
      esr_byte_o <= se_evt;
    end
  end

  // Mask readbacks
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sre_o <= SB_FIX_EN;
      ese_o <= ZERO_BYTE;
    end else begin
      sre_o <= sre_q;
      ese_o <= se_en;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.poll | req_i.stb_query | req_i.esr_query;
    end
  end

  // Condition inputs (sum_i) are sampled only; no write path exists

endmodule

// ===== testbench/ieeesr_status_sva.sv
`timescale 1ns/1ps
// Port-level checks of the status block
module ieeesr_status_sva (
  input wire logic                       ref_clk_i,   // Clock
  input wire logic                       sys_rst_i,   // Sync reset
  input wire ieeesr_pkg::ieeesr_evt_type evt_i,       // Event causes
  input wire ieeesr_pkg::ieeesr_sum_type sum_i,       // Group summaries
  input wire ieeesr_pkg::ieeesr_req_type req_i,       // Host strobes
  input wire logic                       srq_o,       // Service request
  input wire logic [7:0]                 poll_byte_o, // Poll answer
  input wire logic [7:0]                 stb_byte_o,  // Byte answer
  input wire logic [7:0]                 esr_byte_o,  // Event answer
  input wire logic [7:0]                 sre_o,       // Byte mask
  input wire logic [7:0]                 ese_o,       // Event mask
  input wire logic                       rd_valid_o   // Answer valid
);
  import ieeesr_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Any query strobe; each must be answered
  wire rd_any = req_i.poll | req_i.stb_query | req_i.esr_query;

  mask_bit6_a: assert property (sre_o[SB_MSS_BIT]) else $error("mask bit 6 lost");
  low_bits_a: assert property (stb_byte_o[1:0] == 2'b00 && poll_byte_o[1:0] == 2'b00)
    else $error("status bits 0-1 set");
  esr_bit6_a: assert property (!esr_byte_o[SE_NUL_BIT]) else $error("event bit 6 set");
  answer_pulse_a: assert property (rd_any |=> rd_valid_o) else $error("query unanswered");
  stray_valid_a: assert property (rd_valid_o |-> $past(rd_any)) else $error("answer without query");
  // Service request only drops after a poll or a clear-status
  srq_drop_a: assert property ($fell(srq_o) |-> $past(req_i.poll) || $past(req_i.poll, 2) ||
    $past(req_i.clr_status) || $past(req_i.clr_status, 2)) else $error("srq fell unasked");
  poll_rqs_a: assert property (req_i.poll && srq_o && !req_i.clr_status && !$past(req_i.poll) &&
    !$past(req_i.clr_status) |=> poll_byte_o[SB_MSS_BIT]) else $error("poll lost request flag");
  poll_hold_a: assert property (!req_i.poll && !req_i.clr_status && !$past(req_i.clr_status)
    |=> $stable(poll_byte_o)) else $error("poll answer moved");
  // Readbacks sit one flop behind the mask, so a write shows two edges later
  ese_write_a: assert property (req_i.ese_wr |-> ##2 ese_o == $past(req_i.wdata, 2)) else $error("event mask");
  sre_write_a: assert property (req_i.sre_wr |-> ##2 sre_o == ($past(req_i.wdata, 2) | SB_FIX_EN))
    else $error("byte mask");
  ese_hold_a: assert property (!req_i.ese_wr |-> ##2 $stable(ese_o)) else $error("event mask moved");

  cover property (req_i.poll && srq_o);
  cover property (req_i.clr_status);
  cover property (rd_valid_o && esr_byte_o != 8'h00);
endmodule

bind ieeesr_status ieeesr_status_sva ieeesr_status_sva_inst (.ref_clk_i, .sys_rst_i, .evt_i, .sum_i,
  .req_i, .srq_o, .poll_byte_o, .stb_byte_o, .esr_byte_o, .sre_o, .ese_o, .rd_valid_o);

// ===== testbench/ieeesr_ctrl_model.sv
`timescale 1ns/1ps
// Bus controller: strobes one request, then awaits the answer
module ieeesr_ctrl_model (
  input  wire logic                  ref_clk_i,  // Clock
  input  wire logic                  rd_valid_i, // Answer valid pulse
  output ieeesr_pkg::ieeesr_req_type req_o       // Requests to device
);
  import ieeesr_pkg::*;
  initial req_o = '0;
  // One-edge strobe; a poll or query must answer within four cycles
  task automatic issue(input ieeesr_req_type r, output logic ok);
    int   n;
    logic q;
    n = 0;
    q = r.poll | r.stb_query | r.esr_query;
    @(posedge ref_clk_i);
    #1 req_o = r;
    @(posedge ref_clk_i);
    #1 req_o = '0;
    while (q && rd_valid_i !== 1'b1 && n < 4) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    ok = !q || rd_valid_i === 1'b1;
  endtask
endmodule

// ===== testbench/ieee488_status_reporting_tb_top.sv
`timescale 1ns/1ps
module ieee488_status_reporting_tb_top;
  import ieeesr_pkg::*;
  localparam logic [5:0] OP_POLL = 6'h20;
  localparam logic [5:0] OP_STB  = 6'h10;
  localparam logic [5:0] OP_ESR  = 6'h08;
  localparam logic [5:0] OP_CLS  = 6'h04;
  localparam logic [5:0] OP_SRE  = 6'h02;
  localparam logic [5:0] OP_ESE  = 6'h01;
  logic           ref_clk_i;
  logic           sys_rst_i;
  ieeesr_evt_type evt_i;
  ieeesr_sum_type sum_i;
  ieeesr_req_type req_i;
  logic           srq_o;
  logic           rd_valid_o;
  logic [7:0]     poll_byte_o;
  logic [7:0]     stb_byte_o;
  logic [7:0]     esr_byte_o;
  logic [7:0]     sre_o;
  logic [7:0]     ese_o;
  logic [7:0]     sb_map [4] = '{8'h10, 8'h04, 8'h08, 8'h80};
  int             n_mismatch = 0;
  int             check_count = 0;

  ieeesr_status ieeesr_status_inst (.ref_clk_i, .sys_rst_i, .evt_i, .sum_i, .req_i, .srq_o,
    .poll_byte_o, .stb_byte_o, .esr_byte_o, .sre_o, .ese_o, .rd_valid_o);
  ieeesr_ctrl_model ieeesr_ctrl_model_inst (.ref_clk_i, .rd_valid_i(rd_valid_o), .req_o(req_i));

  // 50 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Strobe flags in the upper six bits, write data below
  task automatic op(input logic [5:0] s, input logic [7:0] d);
    logic ok;
    ieeesr_ctrl_model_inst.issue(ieeesr_req_type'({s, d}), ok);
    check(8'(ok), 8'h01);
  endtask

  task automatic rd(input logic [5:0] s, input logic [7:0] e);
    op(s, 8'h00);
    check(s[5] ? poll_byte_o : s[4] ? stb_byte_o : esr_byte_o, e);
  endtask

  // One-cycle cause pulse, bit 6 is power on
  task automatic ev(input int i);
    @(posedge ref_clk_i);
    #1 evt_i = 7'(1 << i);
    @(posedge ref_clk_i);
    #1 evt_i = '0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Hang guard: the whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    sys_rst_i = 1'b1;
    evt_i = '0;
    sum_i = '0;
    repeat (5) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    check(sre_o, SB_FIX_EN);
    check(ese_o, ZERO_BYTE);
    rd(OP_ESR, PWRUP_EVT);
    rd(OP_ESR, ZERO_BYTE);
    // Every cause sets its own event bit and the query clears it
    for (int i = 0; i < 7; i++) begin
      ev(i);
      rd(OP_ESR, (i == 6) ? 8'h80 : 8'(1 << i));
    end
    op(OP_SRE, 8'hff);
    // Readback flop lags the mask by one edge
    cyc(1);
    check(sre_o, 8'hff);
    op(OP_SRE, 8'h00);
    cyc(1);
    check(sre_o, 8'h40);
    op(OP_ESE, 8'ha5);
    cyc(1);
    check(ese_o, 8'ha5);
    // Each lower summary lands in its status bit, live
    for (int i = 0; i < 4; i++) begin
      sum_i = 4'(1 << i);
      cyc(3);
      rd(OP_STB, sb_map[i]);
      rd(OP_POLL, sb_map[i]);
      sum_i = '0;
    end
    ev(5);
    cyc(3);
    rd(OP_STB, 8'h20);
    rd(OP_ESR, 8'h20);
    ev(4);
    cyc(3);
    rd(OP_STB, 8'h00);
    rd(OP_ESR, 8'h10);
    // Service request from an enabled buffer flag
    op(OP_SRE, 8'h10);
    sum_i = 4'h1;
    cyc(6);
    check(8'(srq_o), 8'h01);
    rd(OP_STB, 8'h50);
    check(8'(srq_o), 8'h01);
    rd(OP_POLL, 8'h50);
    check(8'(srq_o), 8'h00);
    rd(OP_POLL, 8'h10);
    rd(OP_STB, 8'h50);
    op(OP_SRE, 8'h00);
    cyc(2);
    rd(OP_STB, 8'h10);
    op(OP_SRE, 8'h10);
    cyc(6);
    check(8'(srq_o), 8'h01);
    sum_i = '0;
    cyc(3);
    rd(OP_STB, 8'h00);
    check(8'(srq_o), 8'h01);
    // Clear-status drops events and the request
    ev(5);
    op(OP_CLS, 8'h00);
    cyc(2);
    check(8'(srq_o), 8'h00);
    rd(OP_ESR, 8'h00);
    rd(OP_STB, 8'h00);
    finish_test();
  end
endmodule
